// file: src/scc_pkg.sv
// constants for the sensor cpu fetch and execute core
// assumes one clock domain and a read-only byte-wide program memory
package scc_pkg;

  localparam int          DATA_W     = 16;
  localparam int          PC_W       = 16;
  localparam int          MEM_AW     = 12;
  localparam int          NUM_REGS   = 16;
  localparam int          SEL_W      = 4;
  localparam int          OP_W       = 4;
  localparam int          OP_MSB     = 7;
  localparam int          OP_LSB     = 4;
  localparam int          SEL_MSB    = 3;
  localparam int          SEL_LSB    = 0;
  localparam int          MSB        = 15;

  localparam logic [PC_W-1:0]   PC_RESET   = 16'h0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 16'h0001;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 16'h0000;

  // accumulator index is not fixed by the hardware description
  localparam logic [SEL_W-1:0]  ACC_SEL    = 4'h0;
  localparam logic [SEL_W-1:0]  SHIFT_SRC_SEL  = 4'h4;
  localparam logic [SEL_W-1:0]  SHIFT_LINK_SEL = 4'h6;

  localparam logic [OP_W-1:0] OP_LOAD_IMMEDIATE   = 4'h0;
  localparam logic [OP_W-1:0] OP_CLEAR_REGISTER   = 4'h1;
  localparam logic [OP_W-1:0] OP_AND_WITH_ACC     = 4'h2;
  localparam logic [OP_W-1:0] OP_OR_WITH_ACC      = 4'h3;
  localparam logic [OP_W-1:0] OP_ADD_TO_ACC       = 4'h4;
  localparam logic [OP_W-1:0] OP_STORE_ACC        = 4'h5;
  localparam logic [OP_W-1:0] OP_SHIFT_LEFT_REG   = 4'h6;
  localparam logic [OP_W-1:0] OP_SHIFT_RIGHT_ARITH = 4'h7;

  typedef enum logic [1:0] {
    SCC_FETCH,
    SCC_LOAD_HIGH,
    SCC_LOAD_LOW
  } scc_state_e;

endpackage : scc_pkg

// file: src/scc_alu.sv
// single-cycle operation unit for the sensor cpu core
// assumes the caller presents the accumulator and selected register
`timescale 1ns/1ps
module scc_alu
  import scc_pkg::*;
(
  // decoded instruction
  input  wire logic [scc_pkg::OP_W-1:0]   op,
  input  wire logic [scc_pkg::SEL_W-1:0]  sel,
  // operands
  input  wire logic [scc_pkg::DATA_W-1:0] acc,
  input  wire logic [scc_pkg::DATA_W-1:0] xreg,
  input  wire logic                       link_bit,
  // result
  output logic      [scc_pkg::DATA_W-1:0] result,
  output logic                            to_acc,
  output logic                            wr_en
);

  import scc_pkg::*;

  always_comb begin
    result = xreg;
    to_acc = 1'b0;
    wr_en  = 1'b1;
    case (op)
      OP_CLEAR_REGISTER: begin
        result = ZERO_WORD;
      end
      OP_AND_WITH_ACC: begin
        result = acc & xreg;
        to_acc = 1'b1;
      end
      OP_OR_WITH_ACC: begin
        result = acc | xreg;
        to_acc = 1'b1;
      end
      OP_ADD_TO_ACC: begin
        // carry dropped on purpose, no flag exists
        result = DATA_W'(acc + xreg);
        to_acc = 1'b1;
      end
      OP_STORE_ACC: begin
        result = acc;
      end
      OP_SHIFT_LEFT_REG: begin
        result = (sel == SHIFT_LINK_SEL) ?
                 {xreg[MSB-1:0], link_bit} :
                 {xreg[MSB-1:0], 1'b0};
      end
      OP_SHIFT_RIGHT_ARITH: begin
        result = {xreg[MSB], xreg[MSB:1]};
      end
      default: begin
        // load handled by the sequencer; uncovered codes change nothing
        wr_en = 1'b0;
      end
    endcase
  end

endmodule : scc_alu

// file: src/scc_core.sv
// fetch and execute core of a small 16-bit sensor compensation cpu
// assumes a byte memory whose read data follows mem_addr in the same cycle
`timescale 1ns/1ps
module scc_core
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // program memory read port
  output logic      [scc_pkg::MEM_AW-1:0]  mem_addr,
  input  wire logic [7:0]                  mem_rdata,
  // observation
  input  wire logic [scc_pkg::SEL_W-1:0]   dbg_sel,
  output logic      [scc_pkg::DATA_W-1:0]  dbg_data,
  output logic      [scc_pkg::PC_W-1:0]    pc,
  output logic                             instr_done
);

  import scc_pkg::*;

  // sequencer
  scc_state_e              state_reg;
  scc_state_e              state_next;
  logic [PC_W-1:0]         pc_reg;
  logic [PC_W-1:0]         pc_next;
  logic [SEL_W-1:0]        dest_reg;
  logic [SEL_W-1:0]        dest_next;
  logic [7:0]              high_reg;
  logic [7:0]              high_next;
  // register file
  logic [DATA_W-1:0]       regs_reg  [NUM_REGS];
  logic [DATA_W-1:0]       regs_next [NUM_REGS];
  // observation
  logic [DATA_W-1:0]       dbg_reg;
  logic [DATA_W-1:0]       dbg_next;
  logic                    done_reg;
  logic                    done_next;

  // decode and write request
  logic [OP_W-1:0]         op;
  logic [SEL_W-1:0]        sel;
  logic [DATA_W-1:0]       alu_result;
  logic                    alu_to_acc;
  logic                    alu_wr_en;
  logic                    wr_en;
  logic [SEL_W-1:0]        wr_sel;
  logic [DATA_W-1:0]       wr_data;
  logic                    retire;

  // plain byte step; the top four bits wrap but never reach the memory
  function automatic logic [PC_W-1:0] pc_advance(
    input logic [PC_W-1:0] p
  );
    return p + PC_STEP;
  endfunction : pc_advance

  function automatic logic [OP_W-1:0] op_field(
    input logic [7:0] b
  );
    return b[OP_MSB:OP_LSB];
  endfunction : op_field

  function automatic logic [SEL_W-1:0] sel_field(
    input logic [7:0] b
  );
    return b[SEL_MSB:SEL_LSB];
  endfunction : sel_field

  // decode straight off the memory byte, so no fetch latch is needed
  assign op  = op_field(mem_rdata);
  assign sel = sel_field(mem_rdata);

  // link bit is the top bit of register four as it stands before this instruction
  scc_alu u_alu (
    .op       (op),
    .sel      (sel),
    .acc      (regs_reg[ACC_SEL]),
    .xreg     (regs_reg[sel]),
    .link_bit (regs_reg[SHIFT_SRC_SEL][MSB]),
    .result   (alu_result),
    .to_acc   (alu_to_acc),
    .wr_en    (alu_wr_en)
  );

  // sequencer: program counter and load operand steps
  always_comb begin
    state_next = state_reg;
    pc_next    = pc_reg;
    dest_next  = dest_reg;
    high_next  = high_reg;
    case (state_reg)
      SCC_FETCH: begin
        // uncovered opcodes still step, so a stray byte cannot stall
        pc_next = pc_advance(pc_reg);
        if (op == OP_LOAD_IMMEDIATE) begin
          // target kept; the operand bytes follow in order
          dest_next  = sel;
          state_next = SCC_LOAD_HIGH;
        end
      end
      SCC_LOAD_HIGH: begin
        high_next  = mem_rdata;
        pc_next    = pc_advance(pc_reg);
        state_next = SCC_LOAD_LOW;
      end
      SCC_LOAD_LOW: begin
        pc_next    = pc_advance(pc_reg);
        // next fetch only once pc already points past the operands
        state_next = SCC_FETCH;
      end
      default: begin
        state_next = SCC_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= SCC_FETCH;
      pc_reg    <= PC_RESET;
      dest_reg  <= ACC_SEL;
      high_reg  <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      dest_reg  <= dest_next;
      high_reg  <= high_next;
    end
  end

  // one write per cycle at most, to one destination only
  always_comb begin
    wr_en   = 1'b0;
    wr_sel  = sel;
    wr_data = alu_result;
    retire  = 1'b0;
    case (state_reg)
      SCC_FETCH: begin
        if (op != OP_LOAD_IMMEDIATE) begin
          retire = 1'b1;
          wr_en  = alu_wr_en;
          if (alu_to_acc) begin
            wr_sel = ACC_SEL;
          end
        end
      end
      SCC_LOAD_LOW: begin
        retire  = 1'b1;
        wr_en   = 1'b1;
        wr_sel  = dest_reg;
        wr_data = {high_reg, mem_rdata};
      end
      default: begin
        retire = 1'b0;
      end
    endcase
  end

  // register file; reset clears all sixteen, accumulator included
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (wr_en) begin
      regs_next[wr_sel] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= ZERO_WORD;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= regs_next[i];
      end
    end
  end

  // observation: post-update view, registered on the same edge as the write
  // costs a read mux on the next-value array, but shows no stale word
  always_comb begin
    dbg_next  = regs_next[dbg_sel];
    done_next = retire;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dbg_reg  <= ZERO_WORD;
      done_reg <= 1'b0;
    end else begin
      dbg_reg  <= dbg_next;
      done_reg <= done_next;
    end
  end

  // upper four pc bits never reach the memory; no write port exists
  assign mem_addr   = pc_reg[MEM_AW-1:0];
  assign pc         = pc_reg;
  assign dbg_data   = dbg_reg;
  assign instr_done = done_reg;

endmodule : scc_core

// file: dv/scc_flash_model.sv
// read-only byte memory standing in for the program flash
// assumes the bench preloads mem before it releases reset
`timescale 1ns/1ps
module scc_flash_model (
  // read port
  input  wire logic [11:0] addr,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [4096];
  // no write port at all: the core can only read
  assign rdata = mem[addr];
endmodule : scc_flash_model

// file: dv/scc_core_sva.sv
// assertions on the ports of the fetch and execute core
// assumes one clock and a byte read back in the cycle it is addressed
`timescale 1ns/1ps
module scc_core_sva
  import scc_pkg::*;
(
  // core ports, watched only
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [11:0] mem_addr,
  input wire logic [7:0]  mem_rdata,
  input wire logic [3:0]  dbg_sel,
  input wire logic [15:0] dbg_data,
  input wire logic [15:0] pc,
  input wire logic        instr_done
);
  // phase 0 means a fresh opcode sits on mem_rdata
  logic [1:0] ph_reg, ph_next;
  logic [3:0] ds_reg, ds_next;
  logic [3:0] op;
  logic       f, op0, mine;
  assign op = mem_rdata[7:4];
  assign f = ph_reg == 2'h0;
  assign op0 = op == OP_LOAD_IMMEDIATE;
  // dbg_data only shows the target when the view held for a cycle
  assign mine = dbg_sel == mem_rdata[3:0] && dbg_sel == ds_reg;
  always_comb begin
    ds_next = dbg_sel;
    ph_next = (f && !op0) || ph_reg == 2'h2 ? 2'h0 : ph_reg + 2'h1;
    if (srst) ph_next = 2'h0;
  end
  always_ff @(posedge clk) begin
    ph_reg <= ph_next;
    ds_reg <= ds_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wait;
    !instr_done && pc == $past(pc) + 16'h0001;
  endsequence
  sequence s_done;
    instr_done && pc == $past(pc) + 16'h0001;
  endsequence
  a_addr_low_bits: assert property (mem_addr == pc[11:0])
    else $error("address is not the low pc bits");
  a_reset_start: assert property ($fell(srst) |-> pc == 16'h0000)
    else $error("pc not zero after reset");
  a_single_step: assert property (f && !op0 |=> s_done)
    else $error("single byte step wrong");
  a_load_three: assert property (f && op0 |=> s_wait ##1 s_wait ##1 s_done)
    else $error("load step sequence wrong");
  a_clear_zero: assert property (f && op == OP_CLEAR_REGISTER && mine
    |=> dbg_data == 16'h0000) else $error("clear left data");
  a_shift_left: assert property (f && op == OP_SHIFT_LEFT_REG && mine
    && dbg_sel != SHIFT_LINK_SEL |=> dbg_data == {$past(dbg_data[14:0]), 1'b0})
    else $error("left shift wrong");
  a_shift_right: assert property (f && op == OP_SHIFT_RIGHT_ARITH && mine
    |=> dbg_data == {$past(dbg_data[15]), $past(dbg_data[15:1])})
    else $error("right shift wrong");
  a_add_wraps: assert property (f && op == OP_ADD_TO_ACC && mine
    && dbg_sel == ACC_SEL |=> dbg_data == $past(dbg_data) + $past(dbg_data))
    else $error("add result wrong");
  a_store_keeps: assert property (f && op == OP_STORE_ACC && ds_reg == ACC_SEL
    && dbg_sel == ACC_SEL && mem_rdata[3:0] != ACC_SEL |=> $stable(dbg_data))
    else $error("store changed accumulator");
endmodule : scc_core_sva

// file: dv/test_sensor_cpu_core_alu_ops.sv
// self-checking bench: preloads programs, runs them, reads registers back
// assumes the core executes one program byte per cycle after reset
`timescale 1ns/1ps
module test_sensor_cpu_core_alu_ops;
  import scc_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  dbg_sel = 4'h0;
  logic [11:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic [15:0] dbg_data;
  logic [15:0] pc;
  logic        instr_done;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  always #2 clk = ~clk;
  scc_core i_scc_core (.clk(clk), .srst(srst), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .dbg_sel(dbg_sel), .dbg_data(dbg_data),
    .pc(pc), .instr_done(instr_done));
  scc_flash_model i_scc_flash_model (.addr(mem_addr), .rdata(mem_rdata));
  task automatic summarize;
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic cmp(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // F0 filler is an uncovered opcode, so parked code never writes
  task automatic boot(input logic [191:0] p, input int n);
    srst = 1'b1;
    for (int i = 0; i < 4096; i++) i_scc_flash_model.mem[i] = 8'hF0;
    for (int i = 0; i < n; i++) i_scc_flash_model.mem[i] = p[8*(n-1-i)+:8];
    repeat (4) @(negedge clk);
    srst = 1'b0;
  endtask : boot
  // one byte per cycle from reset, so pc must equal the cycle count
  task automatic upto(input logic [15:0] p);
    repeat (p) @(negedge clk);
    cmp("pc", p, pc);
  endtask : upto
  task automatic peek(input logic [3:0] s, input logic [15:0] e);
    dbg_sel = s;
    @(negedge clk);
    cmp($sformatf("register %0d", s), e, dbg_data);
  endtask : peek
  task automatic t_load;
    boot(192'h0A1234_0FFFFF, 6);
    upto(16'h0003);
    cmp("done", 16'h0001, {15'h0000, instr_done});
    @(negedge clk);
    cmp("done", 16'h0000, {15'h0000, instr_done});
    repeat (2) @(negedge clk);
    cmp("pc", 16'h0006, pc);
    peek(4'hA, 16'h1234);
    peek(4'hF, 16'hFFFF);
  endtask : t_load
  task automatic t_logic;
    dbg_sel = 4'h0;
    boot(192'h008001_03FF0F_23_33_40_51, 10);
    upto(16'h000A);
    peek(4'h0, 16'hFE1E);
    peek(4'h1, 16'hFE1E);
    peek(4'h3, 16'hFF0F);
  endtask : t_logic
  task automatic t_shift;
    dbg_sel = 4'h2;
    boot(192'h021234_12_028003_048000_064001_72_62_66_74, 17);
    upto(16'h0011);
    peek(4'h2, 16'h8002);
    peek(4'h6, 16'h8003);
    peek(4'h4, 16'hC000);
  endtask : t_shift
  initial begin
    t_load();
    t_logic();
    t_shift();
    summarize();
  end
  // whole run needs about fifty cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end
endmodule : test_sensor_cpu_core_alu_ops
bind scc_core scc_core_sva i_scc_core_sva (.clk(clk), .srst(srst),
  .mem_addr(mem_addr), .mem_rdata(mem_rdata), .dbg_sel(dbg_sel),
  .dbg_data(dbg_data), .pc(pc), .instr_done(instr_done));
